// >>> design/volt_range_pkg.sv
/*
 Shared constants, types and lookup functions for the voltage range,
 autorange and resolution controller.
 Assumes an analog front end that reports magnitudes as counts of the
 selected range's full scale.
*/
package volt_range_pkg;

   // Register port and sample magnitude widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MAG_W  = 24;

   // Byte offsets of the registers
   localparam logic [7:0] OFS_CTRL         = 8'h00;
   localparam logic [7:0] OFS_DC_RANGE     = 8'h04;
   localparam logic [7:0] OFS_DC_AUTO      = 8'h08;
   localparam logic [7:0] OFS_AC_RANGE     = 8'h0c;
   localparam logic [7:0] OFS_AC_AUTO      = 8'h10;
   localparam logic [7:0] OFS_DC_RES       = 8'h14;
   localparam logic [7:0] OFS_DC_RANGE_MIN = 8'h18;
   localparam logic [7:0] OFS_DC_RANGE_MAX = 8'h1c;
   localparam logic [7:0] OFS_AC_RANGE_MIN = 8'h20;
   localparam logic [7:0] OFS_AC_RANGE_MAX = 8'h24;
   localparam logic [7:0] OFS_READING      = 8'h28;
   localparam logic [7:0] OFS_READ_STATE   = 8'h2c;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h30;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h34;

   // Field positions in written words and in the reading word
   localparam int CTRL_FACTORY_BIT = 0;
   localparam int AUTO_BIT         = 0;
   localparam int CODE_LSB         = 0;
   localparam int CODE_W           = 3;
   localparam int KIND_LSB         = 4;
   localparam int READ_SIGN_BIT    = 24;
   localparam int READ_RANGE_LSB   = 28;

   // Range codes, one step per decade (20 mV is the odd first step)
   localparam logic [2:0] RANGE_20MV   = 3'h0;
   localparam logic [2:0] RANGE_100MV  = 3'h1;
   localparam logic [2:0] RANGE_1V     = 3'h2;
   localparam logic [2:0] RANGE_10V    = 3'h3;
   localparam logic [2:0] RANGE_100V   = 3'h4;
   localparam logic [2:0] RANGE_1000V  = 3'h5;
   localparam logic [2:0] DC_MIN_CODE  = RANGE_20MV;
   localparam logic [2:0] DC_MAX_CODE  = RANGE_1000V;
   localparam logic [2:0] AC_MIN_CODE  = RANGE_100MV;
   localparam logic [2:0] AC_MAX_CODE  = RANGE_1000V;

   // Factory reset values
   localparam logic [2:0] FACTORY_RANGE = RANGE_100MV;
   localparam logic       FACTORY_AUTO  = 1'b1;

   // Resolution steps, value is ten to the code in 0.1 uV
   localparam logic [2:0] RES_MIN_CODE = 3'h0;
   localparam logic [2:0] RES_MAX_CODE = 3'h6;
   localparam logic [2:0] FACTORY_RES  = RES_MIN_CODE;

   // Autorange thresholds in percent of full scale
   localparam int         DOWN_PCT          = 10;
   localparam int         UP_PCT            = 120;
   localparam logic [23:0] FULL_SCALE_COUNTS = 24'h0186a0;
   localparam logic [23:0] DOWN_COUNTS       = 24'(FULL_SCALE_COUNTS * DOWN_PCT / 100);
   localparam logic [23:0] UP_COUNTS         = 24'(FULL_SCALE_COUNTS * UP_PCT / 100);

   // Settling time after an autorange step
   localparam int SETTLE_CYCLES = 16;

   // Interrupt event positions
   localparam int IRQ_DC_CHANGE = 0;
   localparam int IRQ_AC_CHANGE = 1;
   localparam int IRQ_OVERLOAD  = 2;
   localparam int IRQ_SETTLED   = 3;
   localparam int IRQ_N         = 4;

   // How a written range or resolution is to be taken
   typedef enum logic [1:0] {KIND_VALUE, KIND_MIN, KIND_MAX, KIND_DEF} set_kind_t;

   // Reading sentinels: +9.9E+37, -9.9E+37 and +9.91E+37 on the host side
   typedef enum logic [1:0] {READ_NORMAL, READ_OVER_POS, READ_OVER_NEG, READ_RANGING} read_state_t;

   // Full scale of a range code in millivolts
   function automatic logic [31:0] range_fs_mv(input logic [2:0] code);
      case (code)
         RANGE_20MV:  range_fs_mv = 32'h00000014;
         RANGE_100MV: range_fs_mv = 32'h00000064;
         RANGE_1V:    range_fs_mv = 32'h000003e8;
         RANGE_10V:   range_fs_mv = 32'h00002710;
         RANGE_100V:  range_fs_mv = 32'h000186a0;
         default:     range_fs_mv = 32'h000f4240;
      endcase
   endfunction

   // Resolution step in units of 0.1 uV
   function automatic logic [31:0] res_step(input logic [2:0] code);
      case (code)
         3'h0:    res_step = 32'h00000001;
         3'h1:    res_step = 32'h0000000a;
         3'h2:    res_step = 32'h00000064;
         3'h3:    res_step = 32'h000003e8;
         3'h4:    res_step = 32'h00002710;
         3'h5:    res_step = 32'h000186a0;
         default: res_step = 32'h000f4240;
      endcase
   endfunction

endpackage

// >>> design/event_irq.sv
/*
 Sticky event status with write-one-to-clear, a mask, and one level
 interrupt output.
 Assumes events are single-cycle pulses on ref_clk.
*/
`timescale 1ns/10ps
module event_irq
#(
   parameter int N = 4
)
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] events,
   input  wire logic         clr_wr,
   input  wire logic [N-1:0] clr_data,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] mask_data,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);

   genvar i;

   // One sticky bit per event; a new event beats a clear in the same cycle
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               status[i] <= 1'b0;
            else if (events[i])
               status[i] <= 1'b1;
            else if (clr_wr && clr_data[i])
               status[i] <= 1'b0;
         end
      end
   endgenerate

   // Mask register, reset to all gated off
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask <= '0;
      else if (mask_wr)
         mask <= mask_data;
   end

   // Registered so the output comes from a flop; lags status by one cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(status & mask);
   end

endmodule // event_irq

// >>> design/autorange_channel.sv
/*
 Range selection for one voltage function: manual setting, autorange
 stepping with down and up thresholds, and the settling window.
 Assumes magnitudes arrive as counts of the present range's full scale.
*/
`timescale 1ns/10ps
module autorange_channel
import volt_range_pkg::*;
#(
   parameter logic [2:0] MIN_CODE = DC_MIN_CODE,
   parameter logic [2:0] MAX_CODE = DC_MAX_CODE,
   parameter int         SETTLE   = SETTLE_CYCLES
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             factory_rst,
   input  wire logic             set_range,
   input  wire logic [2:0]       set_code,
   input  wire logic             set_auto,
   input  wire logic             auto_val,
   input  wire logic             sample_valid,
   input  wire logic [MAG_W-1:0] sample_mag,
   output logic      [2:0]       range_code,
   output logic                  auto_en,
   output logic                  busy,
   output logic                  changed,
   output logic                  settled
);

   localparam int CNT_W = $clog2(SETTLE + 1);

   logic [CNT_W-1:0] settle_cnt;
   wire  logic       decide;
   wire  logic       step_down;
   wire  logic       step_up;
   wire  logic       settle_done;

   // Only settled readings drive a decision
   assign decide      = sample_valid && auto_en && !busy;
   assign step_down   = decide && (sample_mag < DOWN_COUNTS) && (range_code > MIN_CODE);
   assign step_up     = decide && (sample_mag > UP_COUNTS) && (range_code < MAX_CODE);
   assign settle_done = busy && (settle_cnt == CNT_W'(1));

   // Range and enable; factory reset first, then host writes, then steps
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         range_code <= FACTORY_RANGE;
         auto_en    <= FACTORY_AUTO;
      end
      else if (factory_rst)
      begin
         range_code <= FACTORY_RANGE;
         auto_en    <= FACTORY_AUTO;
      end
      else if (set_range)
      begin
         range_code <= set_code;
         auto_en    <= 1'b0;
      end
      else if (set_auto)
         auto_en <= auto_val;
      else if (step_down)
         range_code <= range_code - 3'h1;
      else if (step_up)
         range_code <= range_code + 3'h1;
   end

   // Settling window; a range write, a factory reset or an autorange-off write cancels it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy       <= 1'b0;
         settle_cnt <= '0;
      end
      else if (factory_rst || set_range || (set_auto && !auto_val))
      begin
         busy       <= 1'b0;
         settle_cnt <= '0;
      end
      else if ((step_down || step_up) && !set_auto)
      begin
         busy       <= 1'b1;
         settle_cnt <= CNT_W'(SETTLE);
      end
      else if (busy)
      begin
         settle_cnt <= settle_cnt - CNT_W'(1);
         busy       <= !settle_done;
      end
   end

   // Event pulses for the interrupt logic
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         changed <= 1'b0;
         settled <= 1'b0;
      end
      else
      begin
         changed <= !factory_rst && !set_range && !set_auto && (step_down || step_up);
         settled <= settle_done && !factory_rst && !set_range && !(set_auto && !auto_val);
      end
   end

endmodule // autorange_channel

// >>> design/volt_range_ctrl.sv
/*
 Range, autorange and DC resolution control for the DC and AC voltage
 functions, with reading status and a register port.
 Assumes a command parser turns text commands into register accesses and
 the front end delivers samples on ref_clk.
*/
// Overview of operation
// - DC accepts 20 mV up to 1000 V; default request turns autorange on.
// - AC accepts 100 mV up to 1000 V; default request turns autorange on.
// - Range read gives present full scale; min/max registers give the limits.
// - Writing a discrete range clears that function's autorange enable.
// - Manual range exceeded gives positive or negative overload reading state.
// - Reading during an autorange step reports ranging; host retries later.
// - Factory reset puts each function at 100 mV with autorange on.
// - Autorange enable is written and read back as 0 or 1.
// - With autorange on, each sample outside the settling window picks the range from the signal.
// - Step down when magnitude is below 10 percent of full scale.
// - Step up when magnitude is above 120 percent of full scale.
// - Min keyword selects the 0.1 uV finest step, max the coarsest.
// - Factory reset sets DC resolution to its finest setting.
`timescale 1ns/10ps
module volt_range_ctrl
import volt_range_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,

   input  wire logic              meas_ac,
   input  wire logic              sample_valid,
   input  wire logic [MAG_W-1:0]  sample_mag,
   input  wire logic              sample_neg,

   output logic      [2:0]        dc_range,
   output logic      [2:0]        ac_range,
   output logic      [2:0]        dc_res,
   output logic                   overload_display_marker,
   output logic                   irq
);

   // Internal nets
   wire  logic [2:0]       wr_code;
   wire  set_kind_t        wr_kind;
   wire  logic             wr_ctrl;
   wire  logic             factory_rst;

   wire  logic             wr_dc_range;
   wire  logic             wr_ac_range;
   wire  logic             wr_dc_auto;
   wire  logic             wr_ac_auto;
   wire  logic             wr_dc_res;
   wire  logic             wr_irq_status;
   wire  logic             wr_irq_mask;

   wire  logic [2:0]       dc_pick;
   wire  logic [2:0]       ac_pick;
   wire  logic             dc_value_ok;
   wire  logic             ac_value_ok;
   wire  logic             dc_set;
   wire  logic             ac_set;
   wire  logic             dc_def;
   wire  logic             ac_def;

   wire  logic [2:0]       res_pick;
   wire  logic             res_ok;

   wire  logic             dc_sample;
   wire  logic             ac_sample;

   wire  logic [2:0]       dc_code;
   wire  logic [2:0]       ac_code;
   wire  logic             dc_auto;
   wire  logic             ac_auto;
   wire  logic             dc_busy;
   wire  logic             ac_busy;
   wire  logic             dc_changed;
   wire  logic             ac_changed;
   wire  logic             dc_settled;
   wire  logic             ac_settled;

   wire  logic [2:0]       act_code;
   wire  logic             act_auto;
   wire  logic             act_busy;
   wire  logic [2:0]       act_max;

   wire  logic             over_fs;
   wire  logic             overload;

   wire  logic [IRQ_N-1:0] events;
   wire  logic [IRQ_N-1:0] irq_status;
   wire  logic [IRQ_N-1:0] irq_mask;

   wire  read_state_t      read_view;
   wire  logic [DATA_W-1:0] next_rdata;

   // Stored state
   logic [MAG_W-1:0]       last_mag;
   logic                   last_neg;
   logic [2:0]             last_range;
   read_state_t            read_state;
   logic [2:0]             res_code;

   // Write decode and field extraction
   assign wr_code       = wdata[CODE_LSB +: CODE_W];
   assign wr_kind       = set_kind_t'(wdata[KIND_LSB +: 2]);
   assign wr_ctrl       = wr && (addr == OFS_CTRL);
   assign factory_rst   = wr_ctrl && wdata[CTRL_FACTORY_BIT];
   assign wr_dc_range   = wr && (addr == OFS_DC_RANGE);
   assign wr_ac_range   = wr && (addr == OFS_AC_RANGE);
   assign wr_dc_auto    = wr && (addr == OFS_DC_AUTO);
   assign wr_ac_auto    = wr && (addr == OFS_AC_AUTO);
   assign wr_dc_res     = wr && (addr == OFS_DC_RES);
   assign wr_irq_status = wr && (addr == OFS_IRQ_STATUS);
   assign wr_irq_mask   = wr && (addr == OFS_IRQ_MASK);

   // Range writes: a value outside the allowed set is dropped silently
   assign dc_value_ok = (wr_code >= DC_MIN_CODE) && (wr_code <= DC_MAX_CODE);
   assign ac_value_ok = (wr_code >= AC_MIN_CODE) && (wr_code <= AC_MAX_CODE);
   assign dc_pick     = (wr_kind == KIND_MIN) ? DC_MIN_CODE :
                        (wr_kind == KIND_MAX) ? DC_MAX_CODE : wr_code;
   assign ac_pick     = (wr_kind == KIND_MIN) ? AC_MIN_CODE :
                        (wr_kind == KIND_MAX) ? AC_MAX_CODE : wr_code;
   assign dc_set      = wr_dc_range && (wr_kind != KIND_DEF) &&
                        ((wr_kind != KIND_VALUE) || dc_value_ok);
   assign ac_set      = wr_ac_range && (wr_kind != KIND_DEF) &&
                        ((wr_kind != KIND_VALUE) || ac_value_ok);
   // Default request means autorange, with the range left where it is
   assign dc_def      = wr_dc_range && (wr_kind == KIND_DEF);
   assign ac_def      = wr_ac_range && (wr_kind == KIND_DEF);

   // Resolution: keywords map to finest and coarsest step; default is finest
   assign res_pick = (wr_kind == KIND_MAX) ? RES_MAX_CODE :
                     (wr_kind == KIND_VALUE) ? wr_code : RES_MIN_CODE;
   assign res_ok   = (wr_kind != KIND_VALUE) || (wr_code <= RES_MAX_CODE);

   // Samples go only to the function that is measuring
   assign dc_sample = sample_valid && !meas_ac;
   assign ac_sample = sample_valid && meas_ac;

   autorange_channel #(
      .MIN_CODE (DC_MIN_CODE),
      .MAX_CODE (DC_MAX_CODE),
      .SETTLE   (SETTLE)
   ) u_dc (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .factory_rst  (factory_rst),
      .set_range    (dc_set),
      .set_code     (dc_pick),
      .set_auto     (wr_dc_auto || dc_def),
      .auto_val     (dc_def || wdata[AUTO_BIT]),
      .sample_valid (dc_sample),
      .sample_mag   (sample_mag),
      .range_code   (dc_code),
      .auto_en      (dc_auto),
      .busy         (dc_busy),
      .changed      (dc_changed),
      .settled      (dc_settled)
   );

   autorange_channel #(
      .MIN_CODE (AC_MIN_CODE),
      .MAX_CODE (AC_MAX_CODE),
      .SETTLE   (SETTLE)
   ) u_ac (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .factory_rst  (factory_rst),
      .set_range    (ac_set),
      .set_code     (ac_pick),
      .set_auto     (wr_ac_auto || ac_def),
      .auto_val     (ac_def || wdata[AUTO_BIT]),
      .sample_valid (ac_sample),
      .sample_mag   (sample_mag),
      .range_code   (ac_code),
      .auto_en      (ac_auto),
      .busy         (ac_busy),
      .changed      (ac_changed),
      .settled      (ac_settled)
   );

   // Active function view for overload and reading status
   assign act_code = meas_ac ? ac_code : dc_code;
   assign act_auto = meas_ac ? ac_auto : dc_auto;
   assign act_busy = meas_ac ? ac_busy : dc_busy;
   assign act_max  = meas_ac ? AC_MAX_CODE : DC_MAX_CODE;
   assign over_fs  = sample_mag > FULL_SCALE_COUNTS;
   // Autorange at the top range has nowhere to go, so it overloads too
   assign overload = sample_valid && over_fs &&
                     (!act_auto || (act_code == act_max));

   // Ranging overrides the stored state while a step settles
   assign read_view = act_busy ? READ_RANGING : read_state;

   // Last reading and its overload state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_mag   <= '0;
         last_neg   <= 1'b0;
         last_range <= FACTORY_RANGE;
         read_state <= READ_NORMAL;
      end
      else if (sample_valid)
      begin
         last_mag   <= sample_mag;
         last_neg   <= sample_neg;
         last_range <= act_code;
         read_state <= !overload ? READ_NORMAL :
                       sample_neg ? READ_OVER_NEG : READ_OVER_POS;
      end
   end

   // DC resolution setting
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         res_code <= FACTORY_RES;
      else if (factory_rst)
         res_code <= FACTORY_RES;
      else if (wr_dc_res && res_ok)
         res_code <= res_pick;
   end

   // Events for the interrupt block
   assign events[IRQ_DC_CHANGE] = dc_changed;
   assign events[IRQ_AC_CHANGE] = ac_changed;
   assign events[IRQ_OVERLOAD]  = overload;
   assign events[IRQ_SETTLED]   = dc_settled || ac_settled;

   event_irq #(
      .N (IRQ_N)
   ) u_irq (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .events    (events),
      .clr_wr    (wr_irq_status),
      .clr_data  (wdata[IRQ_N-1:0]),
      .mask_wr   (wr_irq_mask),
      .mask_data (wdata[IRQ_N-1:0]),
      .status    (irq_status),
      .mask      (irq_mask),
      .irq       (irq)
   );

   // Read selection; unmapped offsets read zero
   assign next_rdata =
      !rd                         ? '0 :
      (addr == OFS_DC_RANGE)      ? range_fs_mv(dc_code) :
      (addr == OFS_AC_RANGE)      ? range_fs_mv(ac_code) :
      (addr == OFS_DC_AUTO)       ? {31'h0, dc_auto} :
      (addr == OFS_AC_AUTO)       ? {31'h0, ac_auto} :
      (addr == OFS_DC_RES)        ? res_step(res_code) :
      (addr == OFS_DC_RANGE_MIN)  ? range_fs_mv(DC_MIN_CODE) :
      (addr == OFS_DC_RANGE_MAX)  ? range_fs_mv(DC_MAX_CODE) :
      (addr == OFS_AC_RANGE_MIN)  ? range_fs_mv(AC_MIN_CODE) :
      (addr == OFS_AC_RANGE_MAX)  ? range_fs_mv(AC_MAX_CODE) :
      (addr == OFS_READING)       ? {1'b0, last_range, 3'h0, last_neg, last_mag} :
      (addr == OFS_READ_STATE)    ? {30'h0, read_view} :
      (addr == OFS_IRQ_STATUS)    ? {{(DATA_W-IRQ_N){1'b0}}, irq_status} :
      (addr == OFS_IRQ_MASK)      ? {{(DATA_W-IRQ_N){1'b0}}, irq_mask} :
      '0;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= '0;
      else
         rdata <= next_rdata;
   end

   // Front-end outputs, registered copies of the selected settings and of the overload state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dc_range                <= FACTORY_RANGE;
         ac_range                <= FACTORY_RANGE;
         dc_res                  <= FACTORY_RES;
         overload_display_marker <= 1'b0;
      end
      else
      begin
         dc_range                <= dc_code;
         ac_range                <= ac_code;
         dc_res                  <= res_code;
         overload_display_marker <= (read_state == READ_OVER_POS) || (read_state == READ_OVER_NEG);
      end
   end

endmodule // volt_range_ctrl

// >>> verif/volt_range_ctrl_sva.sv
/*
 Port checker for the voltage range controller.
 Assumes one strobe at a time, no sample beside a write.
*/
`timescale 1ns/10ps
module volt_range_sva
import volt_range_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
)
(
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic              meas_ac,
   input wire logic              sample_valid,
   input wire logic [MAG_W-1:0]  sample_mag,
   input wire logic              sample_neg,
   input wire logic [2:0]        dc_range,
   input wire logic [2:0]        ac_range,
   input wire logic [2:0]        dc_res,
   input wire logic              overload_display_marker,
   input wire logic              irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Read data only in the cycle after a strobe
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not idle");
   chk_max_query: assert property (rd && addr == OFS_DC_RANGE_MAX |=> rdata == 32'h000f4240)
      else $error("dc maximum range wrong");
   chk_factory_ranges: assert property (wr && addr == OFS_CTRL && wdata[0] |-> ##2 dc_range == FACTORY_RANGE && ac_range == FACTORY_RANGE)
      else $error("factory range wrong");
   chk_factory_res: assert property (wr && addr == OFS_CTRL && wdata[0] |-> ##[1:2] dc_res == FACTORY_RES)
      else $error("factory resolution wrong");
   chk_dc_write: assert property (wr && addr == OFS_DC_RANGE && wdata[5:4] == 2'h0 && wdata[2:0] <= DC_MAX_CODE |-> ##2 dc_range == $past(wdata[2:0], 2))
      else $error("dc range write lost");
   // Range pins never leave the allowed sets
   chk_range_limits: assert property (ac_range >= AC_MIN_CODE && ac_range <= AC_MAX_CODE && dc_range <= DC_MAX_CODE)
      else $error("range outside set");
   // Without a host write a DC range change is one step only
   chk_one_step: assert property ($changed(dc_range) && !$past(wr) && !$past(wr, 2) |-> dc_range == $past(dc_range) + 3'h1 || dc_range + 3'h1 == $past(dc_range))
      else $error("range jumped");
   chk_marker_cause: assert property ($rose(overload_display_marker) |-> $past(sample_valid) || $past(sample_valid, 2))
      else $error("overload without sample");
   chk_mask_quiet: assert property (wr && addr == OFS_IRQ_MASK && wdata[3:0] == 4'h0 |-> ##2 (!irq)[*3])
      else $error("masked interrupt raised");
endmodule // volt_range_sva

bind volt_range_ctrl volt_range_sva #(.SETTLE(SETTLE)) u_sva (.*);

// >>> verif/host_model.sv
/*
 Host model on the register port.
 Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/10ps
module host_model
import volt_range_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic [DATA_W-1:0] rdata,
   output logic      [ADDR_W-1:0] addr  = 8'h00,
   output logic      [DATA_W-1:0] wdata = 32'h0,
   output logic                   wr    = 1'b0,
   output logic                   rd    = 1'b0
);
   // One-cycle write strobe beside address and data
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   // Answer taken at the edge ending the data cycle
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(posedge ref_clk);
      v = rdata;
   endtask
endmodule // host_model

// >>> verif/tb_top.sv
/*
 Self-checking bench for the voltage range controller.
 Assumes the host model owns the register port.
*/
`timescale 1ns/10ps
module tb_top;
import volt_range_pkg::*;
   localparam int ST = 4;
   logic              ref_clk      = 1'b0;
   logic              rst_n        = 1'b0;
   logic              meas_ac      = 1'b0;
   logic              sample_valid = 1'b0;
   logic [MAG_W-1:0]  sample_mag   = 24'h0;
   logic              sample_neg   = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic              wr, rd, marker, irq;
   logic [2:0]        dc_range, ac_range, dc_res;
   int                fail_count = 0;
   int                num_checks = 0;
   always #2 ref_clk = ~ref_clk;
   host_model u_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   volt_range_ctrl #(.SETTLE(ST)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .meas_ac(meas_ac), .sample_valid(sample_valid),
      .sample_mag(sample_mag), .sample_neg(sample_neg), .dc_range(dc_range), .ac_range(ac_range),
      .dc_res(dc_res), .overload_display_marker(marker), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      u_host.rd_reg(a, d);
      chk(d, exp);
   endtask
   // One sample pulse only; callers wait out the settle time for each step except the AC step at the end of t_auto
   task automatic samp(input logic [23:0] m, input logic n);
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample_mag <= m;
      sample_neg <= n;
      @(posedge ref_clk);
      sample_valid <= 1'b0;
   endtask
   task automatic t_reset;
      rchk(OFS_DC_RANGE, 32'h64);
      rchk(OFS_DC_AUTO, 32'h1);
      rchk(OFS_DC_RES, 32'h1);
      chk({29'h0, ac_range}, 32'h1);
      $display("t_reset done");
   endtask
   task automatic t_manual;
      u_host.wr_reg(OFS_DC_RANGE, 32'h3);
      rchk(OFS_DC_RANGE, 32'h2710);
      rchk(OFS_DC_AUTO, 32'h0);
      u_host.wr_reg(OFS_DC_RANGE, 32'h10);
      rchk(OFS_DC_RANGE, 32'h14);
      u_host.wr_reg(OFS_DC_RANGE, 32'h30);
      rchk(OFS_DC_AUTO, 32'h1);
      u_host.wr_reg(OFS_AC_RANGE, 32'h0);
      rchk(OFS_AC_RANGE, 32'h64);
      rchk(OFS_AC_RANGE_MIN, 32'h64);
      rchk(OFS_DC_RANGE_MAX, 32'h000f4240);
      $display("t_manual done");
   endtask
   task automatic t_over;
      u_host.wr_reg(OFS_DC_RANGE, 32'h2);
      u_host.wr_reg(OFS_IRQ_MASK, 32'h4);
      samp(24'h0249f0, 1'b1);
      rchk(OFS_READ_STATE, 32'h2);
      rchk(OFS_IRQ_STATUS, 32'h4);
      chk({31'h0, marker}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      u_host.wr_reg(OFS_IRQ_STATUS, 32'h4);
      rchk(OFS_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("t_over done");
   endtask
   task automatic t_auto;
      u_host.wr_reg(OFS_CTRL, 32'h1);
      u_host.wr_reg(OFS_IRQ_MASK, 32'h1);
      samp(24'h01fbd0, 1'b0);
      rchk(OFS_READ_STATE, 32'h3);
      repeat (ST + 4) @(posedge ref_clk);
      rchk(OFS_READ_STATE, 32'h0);
      rchk(OFS_DC_RANGE, 32'h3e8);
      chk({31'h0, irq}, 32'h1);
      samp(24'h002710, 1'b0);
      rchk(OFS_DC_RANGE, 32'h3e8);
      samp(24'h00270f, 1'b0);
      repeat (ST + 4) @(posedge ref_clk);
      rchk(OFS_DC_RANGE, 32'h64);
      samp(24'h000001, 1'b0);
      repeat (ST + 4) @(posedge ref_clk);
      samp(24'h000001, 1'b0);
      repeat (ST + 4) @(posedge ref_clk);
      rchk(OFS_DC_RANGE, 32'h14);
      meas_ac <= 1'b1;
      samp(24'h01fbd0, 1'b0);
      rchk(OFS_AC_RANGE, 32'h3e8);
      $display("t_auto done");
   endtask
   task automatic t_res;
      u_host.wr_reg(OFS_IRQ_MASK, 32'h0);
      u_host.wr_reg(OFS_DC_RES, 32'h20);
      rchk(OFS_DC_RES, 32'h000f4240);
      u_host.wr_reg(OFS_DC_RES, 32'h10);
      rchk(OFS_DC_RES, 32'h1);
      $display("t_res done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Far above the run length
   initial
   begin
      #40000;
      fail_count++;
      wrap_up();
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_manual();
      t_over();
      t_auto();
      t_res();
      wrap_up();
   end
endmodule // tb_top
